// ---- verilog/ocb_pkg.sv ----
package ocb_pkg;

  localparam int OCB_DATA_W = 32;
  localparam int OCB_ADDR_W = 16;
  localparam int OCB_IDX_W = 14;
  localparam int OCB_BYTE_W = 8;
  localparam int OCB_DIV_W = 10;
  localparam int OCB_PHASE_W = 6;

  // Printed offsets are word indices; the byte address is four times the index.
  localparam logic [OCB_IDX_W-1:0] OCB_IDX_OUT_SETTINGS = 14'h043b;
  localparam logic [OCB_IDX_W-1:0] OCB_IDX_DIV_LOW = 14'h043c;
  localparam logic [OCB_IDX_W-1:0] OCB_IDX_DIV_HIGH = 14'h043d;
  localparam logic [OCB_IDX_W-1:0] OCB_IDX_DIV_PHASE = 14'h043e;

  localparam int OCB_INVERT_BIT = 0;
  localparam int OCB_MODE_LSB = 1;
  localparam int OCB_MODE_MSB = 2;
  localparam int OCB_DIV_HIGH_MSB = 1;
  localparam int OCB_PHASE_MSB = 5;

  localparam logic [1:0] OCB_MODE_14MA = 2'h0;
  localparam logic [1:0] OCB_MODE_21MA = 2'h1;
  localparam logic [1:0] OCB_MODE_28MA = 2'h2;
  localparam logic [1:0] OCB_MODE_OFF = 2'h3;

  localparam logic [1:0] OCB_RST_MODE = OCB_MODE_14MA;
  localparam logic OCB_RST_INVERT = 1'b0;
  localparam logic [7:0] OCB_RST_DIV_LOW = 8'h00;
  localparam logic [1:0] OCB_RST_DIV_HIGH = 2'h0;
  localparam logic [5:0] OCB_RST_PHASE = 6'h00;

endpackage

// ---- verilog/ocb_divider_core.sv ----
`timescale 1ns/10ps
module ocb_divider_core
  import ocb_pkg::*;
#(
  parameter int DIV_W = OCB_DIV_W,
  parameter int PHASE_W = OCB_PHASE_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic half_tick,
  input wire logic sync_pulse,
  input wire logic [DIV_W-1:0] pending_div,
  input wire logic [PHASE_W-1:0] phase,
  output logic level
);

  localparam logic [DIV_W+1:0] HC_ONE = {{(DIV_W+1){1'b0}}, 1'b1};

  typedef struct packed {
    logic [DIV_W:0] pos;
    logic [DIV_W-1:0] div;
    logic level;
  } ocb_core_state_t;

  ocb_core_state_t s;
  ocb_core_state_t next_s;

  // Half periods of the input clock in one output period: 2 * (div + 1).
  function automatic logic [DIV_W+1:0] half_count(input logic [DIV_W-1:0] d);
    return {1'b0, d, 1'b0} + HC_ONE + HC_ONE;
  endfunction

  // Low for the first div+1 half periods, high for the rest.
  function automatic logic level_of(input logic [DIV_W:0] p, input logic [DIV_W-1:0] d);
    return {1'b0, p} > {2'b00, d};
  endfunction

  always_comb begin
    logic [DIV_W+1:0] start;
    start = '0;
    next_s = s;
    if (sync_pulse) begin
      // A phase larger than one period wraps round inside the period.
      start = {{(DIV_W+2-PHASE_W){1'b0}}, phase} % half_count(pending_div);
      next_s.div = pending_div;
      next_s.pos = start[DIV_W:0];
    end else if (half_tick) begin
      if (({1'b0, s.pos} + HC_ONE) == half_count(s.div)) begin
        next_s.pos = '0;
        // Apart from a sync, a new ratio is only taken at a period boundary, so no short pulse appears.
        next_s.div = pending_div;
      end else begin
        next_s.pos = s.pos + 1'b1;
      end
    end
    next_s.level = level_of(next_s.pos, next_s.div);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.level;

endmodule

// ---- verilog/ocb_output_channel_b_divider.sv ----
// Added by the designer: register access over APB.
`timescale 1ns/10ps
// Behaviour
// - mode bits 2:1 select 14/21/28 mA drive.
// - mode 11 powers down, outputs tristated.
// - bit 0 inverts output polarity, reset normal.
// - ten-bit divider split over two registers.
// - divide input clock by value plus one.
// - sync starts divider at half-period phase offset.
// - divider low byte resets to zero.
module ocb_output_channel_b_divider
  import ocb_pkg::*;
#(
  parameter int DIV_W = OCB_DIV_W,
  parameter int PHASE_W = OCB_PHASE_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [OCB_ADDR_W-1:0] paddr,
  input wire logic [OCB_DATA_W-1:0] pwdata,
  output logic [OCB_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic upstream_pre_divider_clk,
  input wire logic sync_request,
  output logic output_channel_b_p,
  output logic output_channel_b_n,
  output logic output_channel_b_oe,
  output logic output_channel_b_power_down,
  output logic [1:0] output_channel_b_drive_mode
);

  // All state of this module, registered together at every rising pclk edge; the divider core keeps its own.
  typedef struct packed {
    logic [2:0] pre_sync;
    logic [2:0] req_sync;
    logic [1:0] mode;
    logic invert;
    logic [7:0] div_low;
    logic [1:0] div_high;
    logic [5:0] phase;
    logic [DIV_W-1:0] pending_div;
    logic [OCB_DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic out_p;
    logic out_n;
    logic out_oe;
    logic power_down;
    logic [1:0] drive_mode;
  } ocb_state_t;

  ocb_state_t s;
  ocb_state_t next_s;
  logic half_tick;
  logic sync_pulse;
  logic core_level;

  // Bit positions of the one-hot register select.
  localparam int SEL_W = 4;
  localparam int SEL_SET = 0;
  localparam int SEL_LOW = 1;
  localparam int SEL_HIGH = 2;
  localparam int SEL_PHASE = 3;

  // Reset leaves the driver enabled in the lowest drive mode with n high and p low.
  localparam ocb_state_t RST_STATE = '{
    pre_sync: '0,
    req_sync: '0,
    mode: OCB_RST_MODE,
    invert: OCB_RST_INVERT,
    div_low: OCB_RST_DIV_LOW,
    div_high: OCB_RST_DIV_HIGH,
    phase: OCB_RST_PHASE,
    pending_div: '0,
    prdata: '0,
    pready: 1'b0,
    pslverr: 1'b0,
    out_p: 1'b0,
    out_n: 1'b1,
    out_oe: 1'b1,
    power_down: 1'b0,
    drive_mode: OCB_RST_MODE
  };

  ////////////////////////////////////////////////////////////////////////////////
  // A register answers only at its own aligned word address.
  function automatic logic addr_hit(input logic [OCB_ADDR_W-1:0] a,
                                    input logic [OCB_IDX_W-1:0] idx);
    return a == {idx, 2'b00};
  endfunction

  function automatic logic [OCB_DATA_W-1:0] widen(input logic [OCB_BYTE_W-1:0] b);
    return {{(OCB_DATA_W-OCB_BYTE_W){1'b0}}, b};
  endfunction

  // One-hot register select, all zero for an address that maps to nothing.
  function automatic logic [SEL_W-1:0] reg_select(input logic [OCB_ADDR_W-1:0] a);
    logic [SEL_W-1:0] sel;
    sel = '0;
    sel[SEL_SET] = addr_hit(a, OCB_IDX_OUT_SETTINGS);
    sel[SEL_LOW] = addr_hit(a, OCB_IDX_DIV_LOW);
    sel[SEL_HIGH] = addr_hit(a, OCB_IDX_DIV_HIGH);
    sel[SEL_PHASE] = addr_hit(a, OCB_IDX_DIV_PHASE);
    return sel;
  endfunction

  // The power-down code is the only mode that releases the driver.
  function automatic logic mode_off(input logic [1:0] m);
    return m == OCB_MODE_OFF;
  endfunction

  // Reserved bits read back as zero, and so does an unmapped address.
  function automatic logic [OCB_DATA_W-1:0] read_word(input logic [SEL_W-1:0] sel,
                                                     input ocb_state_t st);
    logic [OCB_BYTE_W-1:0] b;
    b = '0;
    if (sel[SEL_SET]) begin
      b = {5'h00, st.mode, st.invert};
    end else if (sel[SEL_LOW]) begin
      b = st.div_low;
    end else if (sel[SEL_HIGH]) begin
      b = {6'h00, st.div_high};
    end else if (sel[SEL_PHASE]) begin
      b = {2'h0, st.phase};
    end
    return widen(b);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Both edges of the pre-divider clock are half-period ticks for the divider.
  // The pre-divider clock must stay below half of pclk or ticks are lost.
  assign half_tick = s.pre_sync[1] ^ s.pre_sync[2];
  assign sync_pulse = s.req_sync[1] & ~s.req_sync[2];

  // The core sees only the committed ratio, never a low byte on its own.
  ocb_divider_core #(
    .DIV_W(DIV_W),
    .PHASE_W(PHASE_W)
  ) u_core (
    .pclk(pclk),
    .presetn(presetn),
    .half_tick(half_tick),
    .sync_pulse(sync_pulse),
    .pending_div(s.pending_div),
    .phase(s.phase[PHASE_W-1:0]),
    .level(core_level)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic access;
    logic commit;
    logic [SEL_W-1:0] sel;
    logic clk_out;
    access = psel & penable & ~s.pready;
    commit = psel & penable & s.pready & pwrite;
    sel = reg_select(paddr);
    clk_out = core_level ^ s.invert;
    next_s = s;

    // Stage 0 may be metastable, so logic reads only stages 1 and 2.
    next_s.pre_sync = {s.pre_sync[1:0], upstream_pre_divider_clk};
    next_s.req_sync = {s.req_sync[1:0], sync_request};

    // One wait state: pready rises in the cycle after the access phase starts.
    next_s.pready = access;
    // An unmapped access answers with an error and leaves every register alone.
    next_s.pslverr = access & ~(|sel);
    if (access) begin
      next_s.prdata = read_word(sel, s);
    end

    // Writes land at the edge that completes the transfer.
    if (commit) begin
      if (sel[SEL_SET]) begin
        next_s.mode = pwdata[OCB_MODE_MSB:OCB_MODE_LSB];
        next_s.invert = pwdata[OCB_INVERT_BIT];
      end
      if (sel[SEL_LOW]) begin
        next_s.div_low = pwdata[OCB_BYTE_W-1:0];
      end
      if (sel[SEL_HIGH]) begin
        next_s.div_high = pwdata[OCB_DIV_HIGH_MSB:0];
        // Writing the high byte commits both bytes at once; write low byte first.
        next_s.pending_div = {pwdata[OCB_DIV_HIGH_MSB:0], s.div_low};
      end
      if (sel[SEL_PHASE]) begin
        next_s.phase = pwdata[OCB_PHASE_MSB:0];
      end
    end

    // A powered-down driver lets both legs go, so neither carries the clock.
    next_s.out_oe = ~mode_off(s.mode);
    next_s.power_down = mode_off(s.mode);
    next_s.out_p = next_s.out_oe & clk_out;
    next_s.out_n = next_s.out_oe & ~clk_out;
    next_s.drive_mode = s.mode;
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= RST_STATE;
    end else begin
      s <= next_s;
    end
  end

  // Every output is a register bit, so the pins never glitch on a decode.
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign output_channel_b_p = s.out_p;
  assign output_channel_b_n = s.out_n;
  assign output_channel_b_oe = s.out_oe;
  assign output_channel_b_power_down = s.power_down;
  assign output_channel_b_drive_mode = s.drive_mode;

endmodule

// ---- verification/ocb_asserts.sv ----
`timescale 1ns/10ps
module ocb_asserts
  import ocb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [OCB_DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic output_channel_b_p,
  input wire logic output_channel_b_n,
  input wire logic output_channel_b_oe,
  input wire logic output_channel_b_power_down,
  input wire logic [1:0] output_channel_b_drive_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_PD_MODE: assert property (output_channel_b_power_down == (output_channel_b_drive_mode == 2'h3))
    else $error("power down disagrees with mode");
  AST_TRISTATE: assert property (output_channel_b_power_down |-> !output_channel_b_oe)
    else $error("driver enabled while powered down");
  AST_DRIVE: assert property (output_channel_b_drive_mode != 2'h3 |-> output_channel_b_oe)
    else $error("driver off in a drive mode");
  AST_COMPL: assert property (output_channel_b_oe && $past(output_channel_b_oe) |->
    output_channel_b_n != output_channel_b_p) else $error("outputs not complementary");
  AST_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait state");
  AST_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_ERR: assert property (pslverr |-> pready ##1 !pslverr)
    else $error("error without ready");
  AST_RSVD: assert property (prdata[31:8] == 24'h0)
    else $error("reserved read bits set");
  AST_QUIET: assert property (output_channel_b_power_down |->
    !output_channel_b_p && !output_channel_b_n) else $error("outputs driven while powered down");
  AST_ANSWER: assert property (pready |-> $past(psel) && $past(penable) && !$past(pready))
    else $error("answer without an access phase");
endmodule
bind ocb_output_channel_b_divider ocb_asserts chk_u (.pclk, .presetn, .psel, .penable, .prdata,
  .pready, .pslverr, .output_channel_b_p, .output_channel_b_n, .output_channel_b_oe,
  .output_channel_b_power_down, .output_channel_b_drive_mode);

// ---- verification/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  import ocb_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run = 0, iv, ir;
  logic [15:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, upstream_pre_divider_clk = 0, sync_request = 0;
  logic output_channel_b_p, output_channel_b_n, output_channel_b_oe;
  logic output_channel_b_power_down;
  logic [1:0] output_channel_b_drive_mode;
  logic [33:0] e;
  logic [33:0] expq[$];
  int fails = 0, check_count = 0, seed = 32'h2e9d_f7d9, ticks = 0, ph = 0, t0, t1;
  int ks[3] = '{0, 1, 3};
  int dl[3];
  always #20 pclk = ~pclk;
  ocb_output_channel_b_divider dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .upstream_pre_divider_clk, .sync_request,
    .output_channel_b_p, .output_channel_b_n, .output_channel_b_oe,
    .output_channel_b_power_down, .output_channel_b_drive_mode);
  // The pre-divider clock can be frozen so that a sync lands on a known position.
  always @(posedge pclk) begin
    ph <= (ph == 2 || !run) ? 0 : ph + 1;
    if (run && ph == 2) begin
      upstream_pre_divider_clk <= ~upstream_pre_divider_clk;
      ticks <= ticks + 1;
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // For a read, d is the expected data (zero when err is set); for a write it is the data sent.
  task automatic apb(input logic wr, input logic [13:0] idx, input logic [7:0] d,
                     input logic err = 0);
    int n;
    @(posedge pclk);
    expq.push_back({!wr, err, 24'h0, err ? 8'h00 : d});
    psel <= 1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'($random(seed)), d};
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do @(posedge pclk); while (pready !== 1 && ++n < 20);
    if (n == 20) begin
      fails++;
      complete_run();
    end
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rise(output int tk);
    int n;
    for (n = 0; n < 9000 && output_channel_b_p !== 0; n++) @(posedge pclk);
    for (; n < 9000 && output_channel_b_p !== 1; n++) @(posedge pclk);
    if (n == 9000) begin
      fails++;
      complete_run();
    end
    tk = ticks;
  endtask
  // A new ratio starts at a period wrap, so the first period is skipped.
  task automatic per(input int exp);
    int a, b;
    rise(a);
    rise(a);
    rise(b);
    chk(b - a, exp);
  endtask
  always @(posedge pclk) begin
    if (pready === 1) begin
      if (expq.size() == 0) chk(1, 0);
      else begin
        e = expq.pop_front();
        chk(pslverr, e[32]);
        if (e[33]) chk(prdata, e[31:0]);
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    for (int i = 0; i < 4; i++) apb(0, 14'(OCB_IDX_OUT_SETTINGS + i), 8'h00);
    apb(1, 14'h043f, 8'h55, 1);
    apb(0, 14'h0000, 8'h00, 1);
    // Flipping the drawn bit with the mode makes both polarities appear.
    ir = 1'($random(seed));
    for (int m = 0; m < 4; m++) begin
      iv = 1'(m) ^ ir;
      apb(1, OCB_IDX_OUT_SETTINGS, {5'h00, 2'(m), iv});
      apb(0, OCB_IDX_OUT_SETTINGS, {5'h00, 2'(m), iv});
      repeat (3) @(posedge pclk);
      chk(output_channel_b_drive_mode, m);
      chk({output_channel_b_oe, output_channel_b_power_down}, m == 3 ? 1 : 2);
      chk({output_channel_b_p, output_channel_b_n}, m == 3 ? 0 : {iv, !iv});
    end
    apb(1, OCB_IDX_OUT_SETTINGS, 8'h00);
    run <= 1;
    apb(1, OCB_IDX_DIV_LOW, 8'h02);
    apb(1, OCB_IDX_DIV_HIGH, 8'h00);
    per(6);
    apb(1, OCB_IDX_DIV_LOW, 8'hff);
    per(6);
    apb(1, OCB_IDX_DIV_HIGH, 8'h03);
    apb(0, OCB_IDX_DIV_HIGH, 8'h03);
    per(2048);
    apb(1, OCB_IDX_DIV_LOW, 8'h03);
    apb(1, OCB_IDX_DIV_HIGH, 8'h00);
    foreach (ks[i]) begin
      apb(1, OCB_IDX_DIV_PHASE, 8'(ks[i]));
      run <= 0;
      sync_request <= 0;
      repeat (8) @(posedge pclk);
      sync_request <= 1;
      repeat (8) @(posedge pclk);
      t0 = ticks;
      run <= 1;
      rise(t1);
      dl[i] = t1 - t0;
    end
    chk(dl[0] - dl[1], 1);
    chk(dl[0] - dl[2], 3);
    repeat (4) @(posedge pclk);
    complete_run();
  end
endmodule
